// File: pkg/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
    // bus geometry
    localparam int         AXI_DATA_W     = 32;
    localparam int         AXI_ADDR_W     = 12;
    localparam int         AXI_ADDR_W_MIN = 10;
    // register indices, byte address is four times the index
    localparam logic [7:0] CARD_CTRL_IDX  = 8'h91;
    localparam logic [7:0] PM_CAP_IDX     = 8'ha0;
    // card control byte layout
    localparam int         RING_GATE_BIT  = 7;
    localparam logic       RING_GATE_RST  = 1'h0;
    // capability header layout
    localparam int         WAKE_LSB       = 27;
    localparam int         WAKE_MSB       = 31;
    localparam int         D2_BIT         = 26;
    localparam int         D1_BIT         = 25;
    localparam int         DYN_BIT        = 24;
    localparam int         RSVD_LSB       = 22;
    localparam int         RSVD_MSB       = 23;
    localparam int         DSI_BIT        = 21;
    localparam int         AUX_BIT        = 20;
    localparam int         CLK_BIT        = 19;
    localparam int         VER_LSB        = 16;
    localparam int         VER_MSB        = 18;
    localparam int         NEXT_LSB       = 8;
    localparam int         NEXT_MSB       = 15;
    localparam int         ID_LSB         = 0;
    localparam int         ID_MSB         = 7;
    // capability header contents
    localparam logic [4:0] WAKE_STATES    = 5'h0e;
    localparam logic       SUPPORT_RST    = 1'h0;
    localparam logic       DYN_DATA_VAL   = 1'h0;
    localparam logic       DSI_VAL        = 1'h0;
    localparam logic       AUX_POWER_VAL  = 1'h0;
    localparam logic       NEEDS_CLK_VAL  = 1'h0;
    localparam logic [2:0] VERSION_VAL    = 3'h1;
    localparam logic [7:0] NEXT_PTR_VAL   = 8'h00;
    localparam logic [7:0] CAP_ID_VAL     = 8'h01;
    // bus responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    // channel states
    typedef enum logic [1:0] {
        PMC_WR_COLLECT = 2'b01,
        PMC_WR_RESP    = 2'b10
    } pmc_wr_state_t;
    typedef enum logic [1:0] {
        PMC_RD_IDLE = 2'b01,
        PMC_RD_RESP = 2'b10
    } pmc_rd_state_t;
endpackage
`default_nettype wire

// File: hdl/pmc_regs.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - card control bit 7 gates ring indicate output; resets to 0, disabled.
// - reserved control bits 6:0 and header bits 23:22 read zero, ignore writes.
// - header bits 31:27 list power states that may raise the wake signal.
// - bit 27 clear: no wake from fully-on state.
// - bit 28 set: wake possible from state one.
// - bit 29 set: wake possible from state two.
// - bit 30 set: wake possible from hot off state.
// - bit 31 clear: no wake from cold off state.
// - bit 26 reports state two support, zero by default, one when enabled.
// - bit 25 reports state one support, zero by default, one when enabled.
// - bit 24 reads zero: dynamic data reporting unsupported.
// - bit 21 reads zero: no device specific initialisation needed.
// - bit 20 reads zero: auxiliary power source unsupported.
// - bit 19 reads zero: wake works without the bus clock.
// - bits 18:16 read 001, revision 1.0 compliance.
// - bits 15:8 read zero, end of capability list.
// - bits 7:0 read 01h, power management capability identifier.
// - capability header is read only; writes leave it unchanged.
module pmc_regs #(
    parameter int ADDR_W = pmc_pkg::AXI_ADDR_W
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // write address channel
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    // write data channel
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    // write response channel
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // read address channel
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    // read data channel
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // straps and ring path
    input  wire logic                strap_state_one_en,
    input  wire logic                strap_state_two_en,
    input  wire logic                ring_indicate_src,
    output var  logic                ring_indicate_output
);

    initial begin
        if (ADDR_W < pmc_pkg::AXI_ADDR_W_MIN || ADDR_W > 32) begin
            $error("pmc_regs: ADDR_W out of range");
        end
        if (pmc_pkg::RING_GATE_BIT > 7) begin
            $error("pmc_regs: gate bit outside control byte");
        end
        if (pmc_pkg::WAKE_MSB - pmc_pkg::WAKE_LSB != 4) begin
            $error("pmc_regs: wake field not five bits");
        end
        if (pmc_pkg::RSVD_MSB - pmc_pkg::RSVD_LSB != 1) begin
            $error("pmc_regs: reserved field not two bits");
        end
        if (pmc_pkg::VER_MSB - pmc_pkg::VER_LSB != 2) begin
            $error("pmc_regs: version field not three bits");
        end
        if (pmc_pkg::NEXT_MSB - pmc_pkg::NEXT_LSB != 7) begin
            $error("pmc_regs: next pointer not one byte");
        end
        if (pmc_pkg::ID_MSB - pmc_pkg::ID_LSB != 7) begin
            $error("pmc_regs: identifier not one byte");
        end
        if (pmc_pkg::CARD_CTRL_IDX == pmc_pkg::PM_CAP_IDX) begin
            $error("pmc_regs: register indices collide");
        end
    end

    // byte addresses of the two registers
    localparam logic [ADDR_W-1:0] CTRL_ADDR =
        ADDR_W'({pmc_pkg::CARD_CTRL_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] CAP_ADDR  =
        ADDR_W'({pmc_pkg::PM_CAP_IDX, 2'b00});

    // channel state
    pmc_pkg::pmc_wr_state_t wr_state_q;
    pmc_pkg::pmc_wr_state_t wr_state_d;
    pmc_pkg::pmc_rd_state_t rd_state_q;
    pmc_pkg::pmc_rd_state_t rd_state_d;

    // write holding
    logic                awready_q;
    logic                wready_q;
    logic                aw_full_q;
    logic                w_full_q;
    logic [ADDR_W-1:0]   aw_addr_q;
    logic [31:0]         w_data_q;
    logic [3:0]          w_strb_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;

    // read holding
    logic                arready_q;
    logic                rvalid_q;
    logic [31:0]         rdata_q;
    logic [1:0]          rresp_q;

    // register contents
    logic                ring_gate_q;
    logic                state_one_q;
    logic                state_two_q;
    logic                strap_done_q;
    logic                ring_out_q;

    // handshakes and decode
    logic                aw_take;
    logic                w_take;
    logic                b_take;
    logic                ar_take;
    logic                r_take;
    logic                wr_fire;
    logic                wr_hit_ctrl;
    logic                wr_hit_cap;
    logic                rd_hit_ctrl;
    logic                rd_hit_cap;
    logic [31:0]         cap_word;
    logic [31:0]         ctrl_word;

    assign aw_take     = s_axi_awvalid && awready_q;
    assign w_take      = s_axi_wvalid && wready_q;
    assign b_take      = bvalid_q && s_axi_bready;
    assign ar_take     = s_axi_arvalid && arready_q && (rd_state_q == pmc_pkg::PMC_RD_IDLE);
    assign r_take      = rvalid_q && s_axi_rready;
    assign wr_fire     = (wr_state_q == pmc_pkg::PMC_WR_COLLECT)
                         && aw_full_q && w_full_q;
    assign wr_hit_ctrl = (aw_addr_q == CTRL_ADDR);
    assign wr_hit_cap  = (aw_addr_q == CAP_ADDR);
    assign rd_hit_ctrl = (s_axi_araddr == CTRL_ADDR);
    assign rd_hit_cap  = (s_axi_araddr == CAP_ADDR);

    // capability header image
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[pmc_pkg::WAKE_MSB:pmc_pkg::WAKE_LSB] =
            pmc_pkg::WAKE_STATES;
        cap_word[pmc_pkg::D2_BIT]  = state_two_q;
        cap_word[pmc_pkg::D1_BIT]  = state_one_q;
        cap_word[pmc_pkg::DYN_BIT] = pmc_pkg::DYN_DATA_VAL;
        cap_word[pmc_pkg::RSVD_MSB:pmc_pkg::RSVD_LSB] = 2'h0;
        cap_word[pmc_pkg::DSI_BIT] = pmc_pkg::DSI_VAL;
        cap_word[pmc_pkg::AUX_BIT] = pmc_pkg::AUX_POWER_VAL;
        cap_word[pmc_pkg::CLK_BIT] = pmc_pkg::NEEDS_CLK_VAL;
        cap_word[pmc_pkg::VER_MSB:pmc_pkg::VER_LSB] =
            pmc_pkg::VERSION_VAL;
        cap_word[pmc_pkg::NEXT_MSB:pmc_pkg::NEXT_LSB] =
            pmc_pkg::NEXT_PTR_VAL;
        cap_word[pmc_pkg::ID_MSB:pmc_pkg::ID_LSB] =
            pmc_pkg::CAP_ID_VAL;
    end

    // card control image, reserved bits zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[pmc_pkg::RING_GATE_BIT] = ring_gate_q;
    end

    // write channel state
    always_comb begin
        wr_state_d = wr_state_q;
        case (wr_state_q)
            pmc_pkg::PMC_WR_COLLECT: begin
                if (wr_fire) begin
                    wr_state_d = pmc_pkg::PMC_WR_RESP;
                end
            end
            pmc_pkg::PMC_WR_RESP: begin
                if (b_take) begin
                    wr_state_d = pmc_pkg::PMC_WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = pmc_pkg::PMC_WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_q <= pmc_pkg::PMC_WR_COLLECT;
        end else begin
            wr_state_q <= wr_state_d;
        end
    end

    // write address ready
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
        end else if (aw_take) begin
            awready_q <= 1'b0;
        end else if (b_take) begin
            awready_q <= 1'b1;
        end
    end

    // write address capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    // write data ready
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wready_q <= 1'b1;
        end else if (w_take) begin
            wready_q <= 1'b0;
        end else if (b_take) begin
            wready_q <= 1'b1;
        end
    end

    // write data capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    // write response valid
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
        end else if (b_take) begin
            bvalid_q <= 1'b0;
        end
    end

    // write response code
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bresp_q <= pmc_pkg::RESP_OKAY;
        end else if (wr_fire && (wr_hit_ctrl || wr_hit_cap)) begin
            bresp_q <= pmc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bresp_q <= pmc_pkg::RESP_SLVERR;
        end
    end

    // card control store, only the gate bit is kept
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_gate_q <= pmc_pkg::RING_GATE_RST;
        end else if (wr_fire && wr_hit_ctrl && w_strb_q[0]) begin
            ring_gate_q <= w_data_q[pmc_pkg::RING_GATE_BIT];
        end
    end

    // header has no store; writes to it are answered and dropped

    // first edge after reset release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // support straps caught once after reset release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_one_q  <= pmc_pkg::SUPPORT_RST;
            state_two_q  <= pmc_pkg::SUPPORT_RST;
        end else if (!strap_done_q) begin
            state_one_q  <= strap_state_one_en;
            state_two_q  <= strap_state_two_en;
        end
    end

    // gated ring output
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_out_q <= 1'b0;
        end else begin
            ring_out_q <= ring_gate_q && ring_indicate_src;
        end
    end

    // read channel state
    always_comb begin
        rd_state_d = rd_state_q;
        case (rd_state_q)
            pmc_pkg::PMC_RD_IDLE: begin
                if (ar_take) begin
                    rd_state_d = pmc_pkg::PMC_RD_RESP;
                end
            end
            pmc_pkg::PMC_RD_RESP: begin
                if (r_take) begin
                    rd_state_d = pmc_pkg::PMC_RD_IDLE;
                end
            end
            default: begin
                rd_state_d = pmc_pkg::PMC_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_q <= pmc_pkg::PMC_RD_IDLE;
        end else begin
            rd_state_q <= rd_state_d;
        end
    end

    // read answer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= pmc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            if (rd_hit_ctrl) begin
                rdata_q <= ctrl_word;
                rresp_q <= pmc_pkg::RESP_OKAY;
            end else if (rd_hit_cap) begin
                rdata_q <= cap_word;
                rresp_q <= pmc_pkg::RESP_OKAY;
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= pmc_pkg::RESP_SLVERR;
            end
        end else if (r_take) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    assign s_axi_awready        = awready_q;
    assign s_axi_wready         = wready_q;
    assign s_axi_bvalid         = bvalid_q;
    assign s_axi_bresp          = bresp_q;
    assign s_axi_arready        = arready_q;
    assign s_axi_rvalid         = rvalid_q;
    assign s_axi_rdata          = rdata_q;
    assign s_axi_rresp          = rresp_q;
    assign ring_indicate_output = ring_out_q;

endmodule // pmc_regs

`default_nettype wire

// File: bench/pmc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_regs_props #(
    parameter int ADDR_W = 12
) (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              strap_state_one_en,
    input wire logic              strap_state_two_en,
    input wire logic              ring_indicate_src,
    input wire logic              ring_indicate_output
);
    localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'(32'h0000_0244);
    localparam logic [ADDR_W-1:0] HDR_A  = ADDR_W'(32'h0000_0280);
    logic              aw_q, w_q, gate_q, first_q, s1_q, s2_q;
    logic [ADDR_W-1:0] waddr_q, raddr_q;
    logic [31:0]       wdata_q;
    logic              wstrb0_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // shadow of the write path and the gate bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {aw_q, w_q, gate_q, wstrb0_q} <= 4'h0;
            waddr_q <= '0;
            wdata_q <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) {aw_q, waddr_q} <= {1'b1, s_axi_awaddr};
            if (s_axi_wvalid && s_axi_wready) {w_q, wdata_q, wstrb0_q} <= {1'b1, s_axi_wdata, s_axi_wstrb[0]};
            if (aw_q && w_q) begin
                {aw_q, w_q} <= 2'h0;
                if (waddr_q == CTRL_A && wstrb0_q) gate_q <= wdata_q[7];
            end
        end
    end
    // straps and read address
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {first_q, s1_q, s2_q} <= 3'h0;
            raddr_q <= '0;
        end else begin
            if (!first_q) {first_q, s1_q, s2_q} <= {1'b1, strap_state_one_en, strap_state_two_en};
            if (s_axi_arvalid && s_axi_arready) raddr_q <= s_axi_araddr;
        end
    end
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence wr_both; aw_q && w_q; endsequence
    sequence hdr_out; s_axi_rvalid && raddr_q == HDR_A; endsequence
    sequence ctrl_out; s_axi_rvalid && raddr_q == CTRL_A; endsequence
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered in one cycle");
    chk_write_answer: assert property (wr_both |=> s_axi_bvalid
        && s_axi_bresp == ((waddr_q == CTRL_A || waddr_q == HDR_A) ? 2'h0 : 2'h2))
        else $error("write response late or wrong");
    chk_ring_path: assert property (
        ring_indicate_output == $past(gate_q && ring_indicate_src)) else $error("ring output wrong");
    chk_ctrl_read: assert property (
        ctrl_out |-> s_axi_rdata == {24'h00_0000, gate_q, 7'h00} && s_axi_rresp == 2'h0)
        else $error("card control read wrong");
    chk_hdr_fixed: assert property (
        hdr_out |-> (s_axi_rdata & 32'hf9ff_ffff) == 32'h7001_0001) else $error("header wrong");
    chk_hdr_straps: assert property (
        hdr_out |-> s_axi_rdata[26:25] == {s2_q, s1_q}) else $error("support bits wrong");
    chk_unmapped_rd: assert property (s_axi_rvalid && raddr_q != CTRL_A && raddr_q != HDR_A
        |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == 2'h2) else $error("unmapped read");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule // pmc_regs_props
bind pmc_regs pmc_regs_props #(.ADDR_W(ADDR_W)) pmc_regs_props_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .strap_state_one_en(strap_state_one_en),
    .strap_state_two_en(strap_state_two_en), .ring_indicate_src(ring_indicate_src),
    .ring_indicate_output(ring_indicate_output));
`default_nettype wire

// File: bench/tb_pmc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pmc_regs;
    logic        ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, strap_state_one_en, strap_state_two_en, ring_indicate_src;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        ring_indicate_output, probe;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, hdr, v;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  prot;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] rexp_q[$];
    logic [1:0]  bexp_q[$];
    logic        gexp_q[$];
    int          bad_count, checks_done;
    pmc_regs pmc_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(prot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(prot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .strap_state_one_en(strap_state_one_en), .strap_state_two_en(strap_state_two_en),
        .ring_indicate_src(ring_indicate_src), .ring_indicate_output(ring_indicate_output));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic miss(input string m);
        $display("MISMATCH %0t %s", $time, m);
        bad_count++;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // result watcher: pops the oldest note per result
    always @(posedge ref_clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            checks_done++;
            if (rexp_q.size() == 0 || {s_axi_rresp, s_axi_rdata} !== rexp_q.pop_front())
                miss("read data or response");
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            checks_done++;
            if (bexp_q.size() == 0 || s_axi_bresp !== bexp_q.pop_front()) miss("write response");
        end
        if (probe === 1'b1) begin
            checks_done++;
            if (gexp_q.size() == 0 || ring_indicate_output !== gexp_q.pop_front()) miss("ring");
        end
    end
    task automatic wait_hi(ref logic s, ref int n);
        while (s !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        int   n;
        logic ad, wd;
        n = 0;
        {ad, wd} = 2'h0;
        bexp_q.push_back(r);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        while (!(ad && wd) && n < 50) begin
            @(posedge ref_clk);
            n++;
            if (!ad && s_axi_awready === 1'b1) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready === 1'b1) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        wait_hi(s_axi_bvalid, n);
        if (!s_axi_bready) begin
            s_axi_bready <= 1'b1;
            @(posedge ref_clk);
        end
        s_axi_bready <= 1'($urandom);
        if (n >= 50) begin miss("no write answer"); summarize(); end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        rexp_q.push_back({r, d});
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        @(posedge ref_clk);
        n = 1;
        wait_hi(s_axi_arready, n);
        s_axi_arvalid <= 1'b0;
        @(posedge ref_clk);
        wait_hi(s_axi_rvalid, n);
        if (!s_axi_rready) begin
            s_axi_rready <= 1'b1;
            @(posedge ref_clk);
        end
        s_axi_rready <= 1'($urandom);
        if (n >= 50) begin miss("no read answer"); summarize(); end
    endtask
    task automatic ring(input logic g);
        logic r;
        repeat (8) begin
            @(posedge ref_clk);
            r = 1'($urandom);
            {ring_indicate_src, probe} <= {r, 1'b0};
            @(posedge ref_clk);
            gexp_q.push_back(g & r);
            probe <= 1'b1;
        end
        @(posedge ref_clk);
        probe <= 1'b0;
    endtask
    initial begin
        v = $urandom(32'h24b4);
        {bad_count, checks_done} = 0;
        {probe, prot, ring_indicate_src} = 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        {strap_state_one_en, strap_state_two_en} = 2'($urandom);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) {strap_state_one_en, strap_state_two_en} <= ~{strap_state_one_en, strap_state_two_en};
            rst_n <= 1'b0;
            repeat (12) @(posedge ref_clk);
            rst_n <= 1'b1;
            @(posedge ref_clk);
            hdr = 32'h7001_0001 | {5'h00, strap_state_two_en, strap_state_one_en, 25'h0};
            rd(12'h244, 32'h0000_0000, 2'h0);
            rd(12'h280, hdr, 2'h0);
            ring(1'b0);
            $display("test reset defaults done");
            if (k == 0) begin
                wr(12'h244, 32'hffff_ffff, 4'h1, 2'h0);
                rd(12'h244, 32'h0000_0080, 2'h0);
                ring(1'b1);
                wr(12'h244, 32'h0000_007f, 4'hf, 2'h0);
                rd(12'h244, 32'h0000_0000, 2'h0);
                wr(12'h244, 32'h0000_0080, 4'he, 2'h0);
                rd(12'h244, 32'h0000_0000, 2'h0);
                wr(12'h280, 32'hffff_ffff, 4'hf, 2'h0);
                rd(12'h280, hdr, 2'h0);
                wr(12'h091, 32'h0000_0080, 4'hf, 2'h2);
                rd(12'h091, 32'h0000_0000, 2'h2);
                rd(12'h004, 32'h0000_0000, 2'h2);
                $display("test control and read only done");
                repeat (6) begin
                    v = $urandom;
                    wr(12'h244, v, 4'h1, 2'h0);
                    rd(12'h244, {24'h00_0000, v[7], 7'h00}, 2'h0);
                end
                wr(12'h244, 32'h0000_0080, 4'h1, 2'h0);
                ring(1'b1);
                $display("test random control done");
            end
        end
        summarize();
    end
endmodule // tb_pmc_regs
`default_nettype wire
